//--- rcds_pkg.sv
// Package with constants and types for the reset cause and delay sequencer
`default_nettype none
package rcds_pkg;
	// Register map (byte addresses, one word each)
	localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
	localparam logic [3:0] ADDR_OSC_STATUS  = 4'h4;
	// Field positions in reset_cause_control
	localparam int BIT_TRAP    = 15;
	localparam int BIT_BADOP   = 14;
	localparam int BIT_VREG    = 8;
	localparam int BIT_PIN     = 7;
	localparam int BIT_SOFT    = 6;
	localparam int BIT_WDTEN   = 5;
	localparam int BIT_TIMEOUT = 4;
	localparam int BIT_SLEEP   = 3;
	localparam int BIT_IDLE    = 2;
	localparam int BIT_BROWN   = 1;
	localparam int BIT_POWERON = 0;
	// Writable bits; 13..9 are unimplemented
	localparam logic [15:0] CAUSE_WMASK = 16'hC1FF;
	localparam logic [15:0] CAUSE_RESET = 16'h0003;
	// Clock rate and nominal delays
	localparam int CLK_HZ         = 40000000;
	localparam int T_POR_NS       = 10000;
	localparam int T_START_REG_NS = 20000;
	localparam int T_START_TIMER_MS = 64;
	localparam int T_RST_NS       = 20000;
	localparam int T_LOCK_NS      = 20000;
	localparam int T_MONITOR_NS   = 100000;
	localparam int OSC_SETTLE_CNT = 1024;
	localparam int CYC_POR        = (T_POR_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_START_REG  = (T_START_REG_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_START_TMR  = T_START_TIMER_MS * (CLK_HZ / 1000);
	localparam int CYC_RST        = (T_RST_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_LOCK       = (T_LOCK_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_MONITOR    = (T_MONITOR_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Oscillator selection codes
	localparam logic [2:0] OSC_FAST_RC = 3'h0;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_POWERON = 3'b001,
		ST_START   = 3'b010,
		ST_INTRST  = 3'b011,
		ST_RUN     = 3'b100
	} rcds_state_t;
	// Which reset is being sequenced
	typedef enum logic [1:0] {
		RK_POWERON = 2'b00,
		RK_BROWN   = 2'b01,
		RK_OTHER   = 2'b10
	} rcds_kind_t;
endpackage
`default_nettype wire

//--- rcds_sequencer.sv
// Reset cause register, reset combiner and release delay sequencer
`default_nettype none
// Summary of operation
// RQ1: Trap conflict reset sets bit 15; only power-on or brown-out clears it.
// RQ2: Bad opcode, address mode or pointer reset sets bit 14; power-on or brown-out clear.
// RQ3: Bits 13 to 9 ignore writes and read zero.
// RQ4: Bit 8 keeps regulator active in sleep; zero lets it stand by.
// RQ5: Pin reset sets bit 7; only power-on clears it, brown-out keeps it.
// RQ6: Reset instruction sets bit 6; power-on or brown-out clears it.
// RQ7: Bit 5 enables watchdog unless config enable forces it on.
// RQ8: Watchdog time-out sets bit 4; power-save instruction, power-on, brown-out clear it.
// RQ9: Sleep sets bit 3, idle sets bit 2; power-on or brown-out clears them.
// RQ10: Brown-out or power-on sets bit 1; power-on sets bit 0; no hardware clear.
// RQ11: Software writes any flag freely; writing never causes a reset.
// RQ12: With switching, power-on and brown-out use config select; others use current select.
// RQ13: Without switching, clock source always comes from config select.
// RQ14: System reset held until power-on and power-up timer delays expire.
// RQ15: Power-on holds reset for power-on, start-up and internal reset times.
// RQ16: Start-up is 20 us with regulator, 64 ms without; brown-out skips power-on delay.
// RQ17: Start-up delay also applied on wake from sleep with regulator on.
// RQ18: Other resets hold system reset only for internal reset time.
// RQ19: Crystal sources after power-on or brown-out wait 1024 oscillator periods.
// RQ20: PLL sources add lock time, running in parallel with reset delays.
// RQ21: Code execution waits until a valid clock reaches the system.
// RQ22: Clock monitor starts 100 us after release; no clock means fast RC.
// RQ23: Any active reset source drives system reset active.
// RQ24: Power-on clears every flag except bits 1 and 0, which it sets.
// RQ25: Delays are counters on the free-running clock, counts from parameters.
module rcds_sequencer #(
	parameter int START_TIMER_CYCLES = rcds_pkg::CYC_START_TMR
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Reset sources and power-save events, one-cycle pulses from on-chip logic
	input  wire logic        powerOnEvent,
	input  wire logic        brownOutEvent,
	input  wire logic        softResetEvent,
	input  wire logic        watchdogEvent,
	input  wire logic        trapConflictEvent,
	input  wire logic        badOpcodeEvent,
	input  wire logic        sleepEnterEvent,
	input  wire logic        idleEnterEvent,
	input  wire logic        wakeFromSleep,
	// Master clear pin, asynchronous, active low
	input  wire logic        masterClearPin_n,
	// Configuration and clock logic
	input  wire logic        configWatchdogEnable,
	input  wire logic        clockSwitchEnable,
	input  wire logic        regulatorEnable,
	input  wire logic [2:0]  configOscSelect,
	input  wire logic [2:0]  currentOscSelect,
	input  wire logic        sourceIsCrystal,
	input  wire logic        sourceUsesPll,
	input  wire logic        oscPeriodTick,
	input  wire logic        clockValid,
	// Outputs to core and clock logic
	output logic             system_reset_n,
	output logic             cpuRun,
	output logic [2:0]       resetOscSelect,
	output logic             watchdogEnable,
	output logic             regulatorStandby,
	output logic             clockMonitorActive,
	output logic             switchToFastRc
);
	typedef struct packed {
		logic [15:0]            cause;
		rcds_pkg::rcds_state_t  state;
		rcds_pkg::rcds_kind_t   kind;
		logic [21:0]            delay;
		logic [9:0]             settleCount;
		logic                   settleDone;
		logic [9:0]             lockCount;
		logic                   lockDone;
		logic                   oscDone;
		logic [12:0]            monitorCount;
		logic                   monitorOn;
		logic                   fastRc;
		logic [2:0]             oscSel;
		logic                   pinSync1;
		logic                   pinSync2;
		logic                   pinPrev;
		logic                   ack;
		logic [31:0]            rdata;
		logic                   sleeping;
	} rcds_reg_t;

	rcds_reg_t cur;
	rcds_reg_t next_cur;

	// Start-up length depends on whether the regulator is on
	function automatic logic [21:0] startLen(input logic regOn);
		if (regOn) begin
			startLen = 22'(rcds_pkg::CYC_START_REG);
		end else begin
			startLen = 22'(START_TIMER_CYCLES);
		end
	endfunction

	// Read-only clock status word
	function automatic logic [31:0] oscWord(input rcds_reg_t s);
		oscWord = 32'h00000000;
		oscWord[2:0] = s.oscSel;
		oscWord[5] = s.oscDone;
		oscWord[6] = s.monitorOn;
		oscWord[7] = s.fastRc;
	endfunction

	logic pinEvent;
	logic anyReset;
	logic accessOk;

	// Flag on the assert edge; the reset itself lasts as long as the pin stays asserted
	assign pinEvent = ~cur.pinPrev & cur.pinSync2;
	assign anyReset = powerOnEvent | brownOutEvent | cur.pinSync2 | softResetEvent
		| watchdogEvent | trapConflictEvent | badOpcodeEvent; // RQ23

	always_comb begin
		next_cur = cur;
		accessOk = (read | write) & ~cur.ack;
		next_cur.ack = accessOk;
		// Pin passes two flops before the edge detector
		next_cur.pinSync1 = ~masterClearPin_n;
		next_cur.pinSync2 = cur.pinSync1;
		next_cur.pinPrev = cur.pinSync2;

		// Software write first so hardware events win in the same cycle
		// The write lands on the edge at which waitrequest is low, never on the waiting edge
		if (cur.ack & write & (address == rcds_pkg::ADDR_RESET_CAUSE)) begin
			if (byteenable[0]) begin
				next_cur.cause[7:0] = writedata[7:0]; // RQ11
			end
			if (byteenable[1]) begin
				next_cur.cause[15:8] = writedata[15:8] & rcds_pkg::CAUSE_WMASK[15:8]; // RQ3
			end
		end
		if (sleepEnterEvent | idleEnterEvent) begin
			next_cur.cause[rcds_pkg::BIT_TIMEOUT] = 1'b0; // RQ8
		end
		if (sleepEnterEvent) begin
			next_cur.cause[rcds_pkg::BIT_SLEEP] = 1'b1; // RQ9
			next_cur.sleeping = 1'b1;
		end
		if (idleEnterEvent) begin
			next_cur.cause[rcds_pkg::BIT_IDLE] = 1'b1; // RQ9
		end
		if (trapConflictEvent) begin
			next_cur.cause[rcds_pkg::BIT_TRAP] = 1'b1; // RQ1
		end
		if (badOpcodeEvent) begin
			next_cur.cause[rcds_pkg::BIT_BADOP] = 1'b1; // RQ2
		end
		if (pinEvent) begin
			next_cur.cause[rcds_pkg::BIT_PIN] = 1'b1; // RQ5
		end
		if (softResetEvent) begin
			next_cur.cause[rcds_pkg::BIT_SOFT] = 1'b1; // RQ6
		end
		if (watchdogEvent) begin
			next_cur.cause[rcds_pkg::BIT_TIMEOUT] = 1'b1; // RQ8
		end
		if (brownOutEvent & ~powerOnEvent) begin
			// Pin flag survives a brown-out
			next_cur.cause[rcds_pkg::BIT_TRAP] = trapConflictEvent; // RQ1
			next_cur.cause[rcds_pkg::BIT_BADOP] = badOpcodeEvent; // RQ2
			next_cur.cause[rcds_pkg::BIT_SOFT] = softResetEvent; // RQ6
			next_cur.cause[rcds_pkg::BIT_TIMEOUT] = watchdogEvent; // RQ8
			next_cur.cause[rcds_pkg::BIT_SLEEP] = 1'b0; // RQ9
			next_cur.cause[rcds_pkg::BIT_IDLE] = 1'b0; // RQ9
			next_cur.cause[rcds_pkg::BIT_BROWN] = 1'b1; // RQ10
		end
		if (powerOnEvent) begin
			next_cur.cause = rcds_pkg::CAUSE_RESET; // RQ24 RQ10
		end

		// Release sequencing
		if (anyReset) begin
			next_cur.monitorOn = 1'b0;
			next_cur.monitorCount = '0;
			next_cur.sleeping = 1'b0;
			if (powerOnEvent) begin
				next_cur.kind = rcds_pkg::RK_POWERON;
				next_cur.state = rcds_pkg::ST_POWERON;
				next_cur.delay = 22'(rcds_pkg::CYC_POR); // RQ15
			end else if (brownOutEvent) begin
				next_cur.kind = rcds_pkg::RK_BROWN;
				next_cur.state = rcds_pkg::ST_START;
				next_cur.delay = startLen(regulatorEnable); // RQ16
			end else begin
				next_cur.kind = rcds_pkg::RK_OTHER;
				next_cur.state = rcds_pkg::ST_INTRST;
				next_cur.delay = 22'(rcds_pkg::CYC_RST); // RQ18
			end
			// Clock choice latched at the reset
			if (clockSwitchEnable & ~(powerOnEvent | brownOutEvent)) begin
				next_cur.oscSel = currentOscSelect; // RQ12
			end else begin
				next_cur.oscSel = configOscSelect; // RQ12 RQ13
			end
			// Oscillator timers start now and run beside the reset delay
			next_cur.settleCount = '0;
			next_cur.lockCount = '0;
			next_cur.settleDone = ~(sourceIsCrystal & (powerOnEvent | brownOutEvent)); // RQ19
			next_cur.lockDone = ~(sourceUsesPll & (powerOnEvent | brownOutEvent)); // RQ20
			next_cur.oscDone = 1'b0;
			next_cur.fastRc = 1'b0;
		end else begin
			case (cur.state)
				rcds_pkg::ST_POWERON: begin
					if (cur.delay <= 22'h000001) begin
						next_cur.state = rcds_pkg::ST_START;
						next_cur.delay = startLen(regulatorEnable); // RQ15 RQ16
					end else begin
						next_cur.delay = cur.delay - 22'h000001; // RQ25
					end
				end
				rcds_pkg::ST_START: begin
					if (cur.delay <= 22'h000001) begin
						next_cur.state = rcds_pkg::ST_INTRST;
						next_cur.delay = 22'(rcds_pkg::CYC_RST); // RQ14
					end else begin
						next_cur.delay = cur.delay - 22'h000001; // RQ25
					end
				end
				rcds_pkg::ST_INTRST: begin
					if (cur.delay <= 22'h000001) begin
						next_cur.state = rcds_pkg::ST_IDLE;
					end else begin
						next_cur.delay = cur.delay - 22'h000001; // RQ25
					end
				end
				rcds_pkg::ST_IDLE: begin
					// Reset released; wait for a valid clock before running code
					if (cur.oscDone) begin
						next_cur.state = rcds_pkg::ST_RUN; // RQ21
					end
				end
				rcds_pkg::ST_RUN: begin
					if (wakeFromSleep & cur.sleeping & regulatorEnable) begin
						next_cur.state = rcds_pkg::ST_IDLE;
						next_cur.delay = startLen(1'b1); // RQ17
						next_cur.sleeping = 1'b0;
					end else if (wakeFromSleep) begin
						next_cur.sleeping = 1'b0;
					end
				end
				default: begin
					next_cur.state = rcds_pkg::ST_IDLE;
				end
			endcase
			// Wake start-up delay reuses the counter while the core waits
			if ((cur.state == rcds_pkg::ST_IDLE) && (cur.delay != '0)) begin
				next_cur.delay = cur.delay - 22'h000001; // RQ17
				next_cur.state = rcds_pkg::ST_IDLE;
			end
			if (~cur.settleDone & oscPeriodTick) begin
				next_cur.settleCount = cur.settleCount + 10'h001; // RQ19
				if (cur.settleCount == 10'(rcds_pkg::OSC_SETTLE_CNT - 1)) begin
					next_cur.settleDone = 1'b1; // RQ19
				end
			end
			if (~cur.lockDone) begin
				next_cur.lockCount = cur.lockCount + 10'h001; // RQ20
				if (cur.lockCount == 10'(rcds_pkg::CYC_LOCK - 1)) begin
					next_cur.lockDone = 1'b1; // RQ20
				end
			end
			next_cur.oscDone = cur.settleDone & cur.lockDone & (clockValid | cur.fastRc); // RQ21
			// Clock monitor for crystal or PLL sources after power-on or brown-out only
			if ((cur.state == rcds_pkg::ST_IDLE || cur.state == rcds_pkg::ST_RUN)
				&& (cur.kind != rcds_pkg::RK_OTHER) && (sourceIsCrystal | sourceUsesPll)
				&& ~cur.monitorOn) begin
				next_cur.monitorCount = cur.monitorCount + 13'h0001; // RQ22
				if (cur.monitorCount == 13'(rcds_pkg::CYC_MONITOR - 1)) begin
					next_cur.monitorOn = 1'b1; // RQ22
				end
			end
			if (cur.monitorOn & ~clockValid & ~cur.fastRc) begin
				next_cur.fastRc = 1'b1; // RQ22
				next_cur.oscSel = rcds_pkg::OSC_FAST_RC; // RQ22
			end
		end

		// Read data registered on the answer cycle
		next_cur.rdata = '0;
		if (accessOk & read) begin
			if (address == rcds_pkg::ADDR_RESET_CAUSE) begin
				next_cur.rdata = {16'h0000, cur.cause & rcds_pkg::CAUSE_WMASK}; // RQ3
			end else if (address == rcds_pkg::ADDR_OSC_STATUS) begin
				next_cur.rdata = oscWord(cur);
			end else begin
				next_cur.rdata = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cur <= '0;
			cur.cause <= rcds_pkg::CAUSE_RESET; // RQ10
			cur.state <= rcds_pkg::ST_POWERON;
			cur.kind <= rcds_pkg::RK_POWERON;
			cur.delay <= 22'(rcds_pkg::CYC_POR);
			// Reset stands for a power-on: clock choice and oscillator timers as after one
			cur.settleDone <= ~sourceIsCrystal; // RQ19
			cur.lockDone <= ~sourceUsesPll; // RQ20
			cur.oscSel <= configOscSelect; // RQ12
		end else begin
			cur <= next_cur;
		end
	end

	assign waitrequest = (read | write) & ~cur.ack;
	assign readdata = cur.rdata;
	// Reset held through every delay stage and during any source pulse
	assign system_reset_n = ~anyReset & ((cur.state == rcds_pkg::ST_IDLE) | (cur.state == rcds_pkg::ST_RUN)); // RQ14 RQ23
	// Core stops in the very cycle a source fires, not one edge later
	assign cpuRun = (cur.state == rcds_pkg::ST_RUN) & ~anyReset; // RQ21 RQ23
	assign resetOscSelect = cur.oscSel;
	assign watchdogEnable = configWatchdogEnable | cur.cause[rcds_pkg::BIT_WDTEN]; // RQ7
	assign regulatorStandby = cur.sleeping & ~cur.cause[rcds_pkg::BIT_VREG]; // RQ4
	assign clockMonitorActive = cur.monitorOn;
	assign switchToFastRc = cur.fastRc;
endmodule
`default_nettype wire

//--- rcds_osc_model.sv
// Oscillator side model: period ticks and clock-valid level
`default_nettype none
module rcds_osc_model (
	// Clock and control
	input  wire logic clk,
	input  wire logic good,
	// To the sequencer
	output logic      oscPeriodTick,
	output logic      clockValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic div = 1'b0;
	// Oscillator slower than the system clock: one tick every second cycle
	always_ff @(posedge clk) div <= ~div;
	assign oscPeriodTick = div;
	assign clockValid = good;
endmodule
`default_nettype wire

//--- rcds_properties.sv
// Port-level checks of the reset sequencer
`default_nettype none
module rcds_properties #(
	parameter int START_TIMER_CYCLES = 50
) (
	// Clock, reset, bus
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Sources and config
	input wire logic        powerOnEvent,
	input wire logic        brownOutEvent,
	input wire logic        softResetEvent,
	input wire logic        watchdogEvent,
	input wire logic        trapConflictEvent,
	input wire logic        badOpcodeEvent,
	input wire logic        masterClearPin_n,
	input wire logic        configWatchdogEnable,
	input wire logic        clockSwitchEnable,
	input wire logic [2:0]  configOscSelect,
	// Outputs
	input wire logic        system_reset_n,
	input wire logic        cpuRun,
	input wire logic [2:0]  resetOscSelect,
	input wire logic        watchdogEnable,
	input wire logic        clockMonitorActive
);
	timeunit 1ns;
	timeprecision 1ps;
	int   lowCnt;
	int   highCnt;
	logic porSeen;
	logic anySrc;
	assign anySrc = powerOnEvent | brownOutEvent | softResetEvent | watchdogEvent | trapConflictEvent | badOpcodeEvent;
	always_ff @(posedge clk) begin
		lowCnt  <= (srst || system_reset_n) ? 0 : lowCnt + 1;
		highCnt <= (srst || !system_reset_n) ? 0 : highCnt + 1;
		porSeen <= (srst || powerOnEvent) ? 1'b1 : (system_reset_n ? 1'b0 : porSeen);
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	AST_SRC_LOW: assert property (anySrc |-> !system_reset_n)
		else $error("source left reset released");
	AST_PIN_LOW: assert property ($fell(masterClearPin_n) |-> ##[2:4] !system_reset_n)
		else $error("pin reset not seen");
	AST_MIN_HOLD: assert property ($rose(system_reset_n) |-> lowCnt >= rcds_pkg::CYC_RST - 1)
		else $error("reset hold too short");
	AST_POR_HOLD: assert property ($rose(system_reset_n) && porSeen |->
		lowCnt >= rcds_pkg::CYC_POR + START_TIMER_CYCLES + rcds_pkg::CYC_RST - 3)
		else $error("power-on hold too short");
	AST_NO_RUN: assert property (!system_reset_n |-> !cpuRun)
		else $error("code runs in reset");
	AST_WDT_FORCE: assert property (configWatchdogEnable |-> watchdogEnable)
		else $error("watchdog not forced on");
	AST_OSC_FIXED: assert property ($rose(cpuRun) && !clockSwitchEnable |-> resetOscSelect == configOscSelect)
		else $error("clock source not from config");
	AST_MONITOR_DELAY: assert property ($rose(clockMonitorActive) |-> highCnt >= rcds_pkg::CYC_MONITOR - 1)
		else $error("monitor started early");
	AST_UNIMP_ZERO: assert property (read && !waitrequest && address == 4'h0 |-> readdata[13:9] == 5'h00)
		else $error("unimplemented bits set");
	AST_ONE_WAIT: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
		else $error("read wait state wrong");
	cover property ($rose(cpuRun));
	cover property ($fell(masterClearPin_n));
	cover property ($rose(clockMonitorActive));
endmodule
bind rcds_sequencer rcds_properties #(.START_TIMER_CYCLES(START_TIMER_CYCLES)) i_rcds_properties (
	.clk(clk), .srst(srst), .address(address), .read(read), .readdata(readdata), .waitrequest(waitrequest),
	.powerOnEvent(powerOnEvent), .brownOutEvent(brownOutEvent), .softResetEvent(softResetEvent),
	.watchdogEvent(watchdogEvent), .trapConflictEvent(trapConflictEvent), .badOpcodeEvent(badOpcodeEvent),
	.masterClearPin_n(masterClearPin_n), .configWatchdogEnable(configWatchdogEnable),
	.clockSwitchEnable(clockSwitchEnable), .configOscSelect(configOscSelect), .system_reset_n(system_reset_n),
	.cpuRun(cpuRun), .resetOscSelect(resetOscSelect), .watchdogEnable(watchdogEnable),
	.clockMonitorActive(clockMonitorActive));
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the reset sequencer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int START_CYC = 50;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [5:0]  evt = 6'h00;
	logic        sleepEv = 1'b0, idleEv = 1'b0, wake = 1'b0, pinN = 1'b1;
	logic        cfgWdt = 1'b0, swEn = 1'b1, regEn = 1'b0, good = 1'b1;
	logic        tick, clkValid, sysRstN, cpuRun, stby, wdtEn, monActive, fastRc;
	logic [2:0]  oscSel;
	int          num_errors = 0;
	int          tests_run = 0;

	rcds_sequencer #(.START_TIMER_CYCLES(START_CYC)) i_rcds_sequencer (.clk(clk), .srst(srst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
		.waitrequest(waitrequest), .powerOnEvent(evt[0]), .brownOutEvent(evt[1]), .softResetEvent(evt[2]),
		.watchdogEvent(evt[3]), .trapConflictEvent(evt[4]), .badOpcodeEvent(evt[5]), .sleepEnterEvent(sleepEv),
		.idleEnterEvent(idleEv), .wakeFromSleep(wake), .masterClearPin_n(pinN), .configWatchdogEnable(cfgWdt),
		.clockSwitchEnable(swEn), .regulatorEnable(regEn), .configOscSelect(3'h5), .currentOscSelect(3'h2),
		.sourceIsCrystal(1'b1), .sourceUsesPll(1'b0), .oscPeriodTick(tick), .clockValid(clkValid),
		.system_reset_n(sysRstN), .cpuRun(cpuRun), .resetOscSelect(oscSel), .watchdogEnable(wdtEn),
		.regulatorStandby(stby), .clockMonitorActive(monActive), .switchToFastRc(fastRc));
	rcds_osc_model i_rcds_osc_model (.clk(clk), .good(good), .oscPeriodTick(tick), .clockValid(clkValid));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic wrap_up;
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Bounded wait on sysRstN (0), cpuRun (1) or the clock monitor (2)
	task automatic waitFor(input int sel, input logic lvl, input int lim, output int n);
		logic [2:0] s;
		n = 0;
		do begin
			@(negedge clk);
			s = {monActive, cpuRun, sysRstN};
			n++;
		end while (s[sel] !== lvl && n < lim);
		if (n >= lim) begin
			num_errors++;
			wrap_up();
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {16'h0000, d};
		n = 0;
		// Sampled at the rising edge itself, before that edge's updates land
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			num_errors++;
			wrap_up();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string w);
		logic [31:0] q;
		bus(1'b0, a, 16'h0000, q);
		check(q, {16'h0000, e}, w);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// Source k pulses for one cycle (6 is the pin); checks hold length and clock choice
	task automatic fire(input int k, input int len, input logic [2:0] osc);
		int n;
		@(posedge clk);
		if (k == 6)
			pinN <= 1'b0;
		else
			evt[k] <= 1'b1;
		@(posedge clk);
		evt <= 6'h00;
		pinN <= 1'b1;
		waitFor(0, 1'b0, 10, n);
		waitFor(0, 1'b1, 5000, n);
		check(n >= len - 4 && n <= len + 2, 1'b1, "hold");
		waitFor(1, 1'b1, 5000, n);
		check(oscSel, osc, "oscsel");
	endtask

	initial begin
		int n;
		automatic int srcs[5] = '{2, 3, 4, 5, 6};
		automatic int pos[5] = '{6, 4, 15, 14, 7};
		automatic logic [15:0] expCause = 16'h0000;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		waitFor(1, 1'b1, 6000, n);
		rd(rcds_pkg::ADDR_RESET_CAUSE, 16'h0003, "cause");
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'hC1FF, "cause");
		check({sysRstN, wdtEn}, 2'b11, "swset");
		wr(4'h0, 16'h0000);
		@(posedge clk);
		cfgWdt <= 1'b1;
		check(wdtEn, 1'b0, "wdt");
		@(negedge clk);
		check(wdtEn, 1'b1, "wdt");
		rd(4'h8, 16'h0000, "unmapped");
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			swEn <= (i != 2);
			fire(srcs[i], rcds_pkg::CYC_RST, i == 2 ? 3'h5 : 3'h2);
			expCause |= 16'h0001 << pos[i];
			rd(4'h0, expCause, "cause");
		end
		@(posedge clk);
		swEn <= 1'b1;
		sleepEv <= 1'b1;
		@(posedge clk);
		sleepEv <= 1'b0;
		@(negedge clk);
		check(stby, 1'b1, "stby");
		rd(4'h0, 16'hC0C8, "cause");
		@(posedge clk);
		regEn <= 1'b1;
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(negedge clk);
		check({sysRstN, cpuRun, stby}, 3'b100, "wake");
		waitFor(1, 1'b1, 1000, n);
		check(n >= rcds_pkg::CYC_START_REG - 10, 1'b1, "wakelen");
		@(posedge clk);
		regEn <= 1'b0;
		idleEv <= 1'b1;
		@(posedge clk);
		idleEv <= 1'b0;
		rd(4'h0, 16'hC0CC, "cause");
		fire(1, START_CYC + rcds_pkg::CYC_RST, 3'h5);
		rd(4'h0, 16'h0082, "cause");
		@(posedge clk);
		good <= 1'b0;
		waitFor(2, 1'b1, 5000, n);
		repeat (2) @(negedge clk);
		check(fastRc, 1'b1, "fastrc");
		@(posedge clk);
		good <= 1'b1;
		fire(0, rcds_pkg::CYC_POR + START_CYC + rcds_pkg::CYC_RST, 3'h5);
		rd(4'h0, 16'h0003, "cause");
		wrap_up();
	end
endmodule
`default_nettype wire
